/* File: bench/rwb_board_model.sv */
`timescale 1ns/1ps
// Board side: reset pin, straps, wake lines, clock status
module rwb_board_model (
	// Clock and sequencer view
	input wire logic clk,
	input wire rwb_pkg::rwb_seq_out_t seq_out,
	// Pins towards the device
	output logic pin_reset_n,
	output logic boot_config_pin,
	output logic test_mode_select,
	output logic boot_select_port_pin,
	output logic serial_rx,
	output logic external_interrupt_zero,
	output rwb_pkg::rwb_clk_status_t clk_status
);
	import rwb_pkg::*;
	logic [2:0] lock_cnt = 3'h0;
	// Idle levels at time zero
	initial begin
		pin_reset_n = 1'b1;
		{boot_config_pin, test_mode_select, boot_select_port_pin} = 3'b100;
		serial_rx = 1'b1;
		external_interrupt_zero = 1'b1;
		clk_status = 4'h8;
	end
	// Lock comes some cycles after attach, so a slow PLL is seen
	always @(posedge clk) begin
		lock_cnt <= seq_out.pll_attach ? lock_cnt + {2'h0, ~&lock_cnt} : 3'h0;
		clk_status.pll_locked <= seq_out.pll_attach && lock_cnt >= 3'h4;
		clk_status.flash_ready <= seq_out.flash_enable;
	end
	task pin_pulse(input int n);
		@(posedge clk) pin_reset_n <= 1'b0;
		repeat (n) @(posedge clk);
		pin_reset_n <= 1'b1;
	endtask
	task straps(input logic [2:0] s);
		@(posedge clk) {boot_config_pin, test_mode_select, boot_select_port_pin} <= s;
	endtask
	task protect(input logic p);
		@(posedge clk) clk_status.flash_protected <= p;
	endtask
	// Short low pulse on one wake line, falling edge counts
	task wake(input logic int0);
		@(posedge clk);
		if (int0) external_interrupt_zero <= 1'b0;
		else serial_rx <= 1'b0;
		repeat (4) @(posedge clk);
		serial_rx <= 1'b1;
		external_interrupt_zero <= 1'b1;
	endtask
endmodule

/* File: bench/rwb_reset_ctrl_tb_top.sv */
`timescale 1ns/1ps
`include "rwb_consts.svh"
// Bench for the reset, wake-up and boot sequencer
module rwb_reset_ctrl_tb_top;
	import rwb_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic brownout_active = 1'b0;
	logic watchdog_expired = 1'b0;
	logic idle_request = 1'b0;
	logic por_low_pdown = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic pin_reset_n, boot_config_pin, test_mode_select, boot_select_port_pin;
	logic serial_rx, external_interrupt_zero, watchdog_nmi, in_power_down, in_idle;
	rwb_clk_status_t clk_status;
	rwb_seq_out_t seq_out;
	rwb_boot_t boot_mode;
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n_cold;
	int n;
	// Straps {mbc,tms,port}, protect, expected mode
	logic [5:0] boot_tbl [5] = '{6'b100000, 6'b001001, 6'b010010, 6'b110011, 6'b010100};
	// 200 MHz clock
	always #2.5 clk = ~clk;
	rwb_reset_ctrl #(.COLD_EVR_CYC(20), .WDT_SEQ_CYC(10), .WAKE_EVR_CYC(15), .WDT_TIMEOUT_CYC(4)) DUT (
		.clk(clk), .resetn(resetn), .pin_reset_n(pin_reset_n), .boot_config_pin(boot_config_pin),
		.test_mode_select(test_mode_select), .boot_select_port_pin(boot_select_port_pin),
		.serial_rx(serial_rx), .external_interrupt_zero(external_interrupt_zero),
		.brownout_active(brownout_active), .por_low_pdown(por_low_pdown), .watchdog_expired(watchdog_expired),
		.idle_request(idle_request), .clk_status(clk_status), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_out(seq_out), .boot_mode(boot_mode),
		.watchdog_nmi(watchdog_nmi), .in_power_down(in_power_down), .in_idle(in_idle));
	rwb_board_model board (
		.clk(clk), .seq_out(seq_out), .pin_reset_n(pin_reset_n), .boot_config_pin(boot_config_pin),
		.test_mode_select(test_mode_select), .boot_select_port_pin(boot_select_port_pin),
		.serial_rx(serial_rx), .external_interrupt_zero(external_interrupt_zero), .clk_status(clk_status));
	task print_verdict;
		$display("checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk) reg_wr <= 1'b0;
	endtask
	task reg_read(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk) reg_rd <= 1'b0;
		#1 chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
	endtask
	// Bounded wait for the core reset to reach a level
	task wait_core(input logic v, output int k);
		k = 0;
		while (seq_out.core_reset_n !== v && k < 2000) begin
			@(posedge clk) #1 k++;
		end
		chk("core_reset_n", {15'h0, v}, {15'h0, seq_out.core_reset_n});
	endtask
	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			print_verdict;
		end
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("pll_attach", 0, seq_out.pll_attach);
		chk("flash_enable", 0, seq_out.flash_enable);
		wait_core(1'b1, n_cold);
		chk("pc_start", 16'h0000, seq_out.pc_start);
		chk("boot_mode", RWB_BOOT_USER, boot_mode);
		reg_read(`RWB_ADDR_PMC, 8'h00);
		reg_write(`RWB_ADDR_PMC, 8'hF3);
		reg_read(`RWB_ADDR_PMC, 8'h13);
		reg_read(4'hF, 8'h00);
		board.pin_pulse(5);
		repeat (25) @(posedge clk);
		#1 chk("short pin pulse", 1, seq_out.core_reset_n);
		$display("test cold_start done");
		board.straps(3'b000);
		@(posedge clk) watchdog_expired <= 1'b1;
		@(posedge clk) watchdog_expired <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("watchdog_nmi", 1, watchdog_nmi);
		wait_core(1'b0, n);
		wait_core(1'b1, n);
		chk("watchdog reset shorter", 1, n < n_cold);
		chk("boot_mode", RWB_BOOT_USER, boot_mode);
		reg_read(`RWB_ADDR_PMC, 8'h40);
		reg_write(`RWB_ADDR_PMC, 8'h40);
		reg_read(`RWB_ADDR_PMC, 8'h00);
		$display("test watchdog done");
		@(posedge clk) brownout_active <= 1'b1;
		repeat (3) @(posedge clk);
		brownout_active <= 1'b0;
		wait_core(1'b0, n);
		wait_core(1'b1, n);
		chk("brownout length", 1, n >= 20);
		chk("boot_mode", RWB_BOOT_LOADER, boot_mode);
		reg_read(`RWB_ADDR_PMC, 8'h00);
		$display("test brownout done");
		@(posedge clk) idle_request <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("in_idle", 1, in_idle);
		board.pin_pulse(25);
		#1 chk("in_idle", 0, in_idle);
		@(posedge clk) idle_request <= 1'b0;
		wait_core(1'b1, n);
		chk("in_idle", 0, in_idle);
		$display("test idle done");
		for (int i = 0; i < 5; i++) begin
			board.straps(boot_tbl[i][5:3]);
			board.protect(boot_tbl[i][2]);
			board.pin_pulse(25);
			wait_core(1'b1, n);
			chk("boot_mode", {14'h0, boot_tbl[i][1:0]}, {14'h0, boot_mode});
		end
		$display("test boot_table done");
		for (int ws = 0; ws < 4; ws++) begin
			reg_write(`RWB_ADDR_PMC, {3'h0, 1'(ws == 3), 2'h1, 2'(ws)});
			repeat (3) @(posedge clk);
			#1 chk("in_power_down", 1, in_power_down);
			board.wake(ws == 2);
			repeat (30) @(posedge clk);
			#1 chk("in_power_down", {15'h0, ws == 0}, {15'h0, in_power_down});
			if (ws == 0) board.pin_pulse(25);
			wait_core(1'b1, n);
			chk("in_power_down", 0, in_power_down);
			reg_read(`RWB_ADDR_PMC, ws == 0 ? 8'h00 : ws == 3 ? 8'h20 : 8'h20 | 8'(ws));
			reg_write(`RWB_ADDR_PMC, 8'h60);
			reg_read(`RWB_ADDR_PMC, 8'h00);
		end
		$display("test wake done");
		reg_write(`RWB_ADDR_PMC, 8'h04);
		repeat (3) @(posedge clk);
		brownout_active <= 1'b1;
		@(posedge clk) brownout_active <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk("in_power_down", 1, in_power_down);
		@(posedge clk) por_low_pdown <= 1'b1;
		wait_core(1'b0, n);
		@(posedge clk) por_low_pdown <= 1'b0;
		wait_core(1'b1, n);
		chk("in_power_down", 0, in_power_down);
		reg_read(`RWB_ADDR_PMC, 8'h00);
		$display("test power_down_brownout done");
		print_verdict;
	end
endmodule

/* File: rtl/rwb_consts.svh */
`ifndef RWB_CONSTS_SVH
`define RWB_CONSTS_SVH
// Register map
`define RWB_ADDR_PMC 4'h0
`define RWB_ADDR_STAT 4'h1
`define RWB_ADDR_CTRL 4'h2
// Power mode register fields
`define RWB_WS_LSB 0
`define RWB_WS_MSB 1
`define RWB_SD_BIT 3
`define RWB_PD_BIT 2
`define RWB_WAKE_RESET_SELECT_BIT 4
`define RWB_WAKE_OCCURRED_FLAG_BIT 5
`define RWB_WDT_BIT 6
`define RWB_RSV_BIT 7
`define RWB_PMC_RST_COLD 8'h00
`define RWB_PMC_RST_WDT 8'h40
`define RWB_PMC_RST_WAKE 8'h20
`define RWB_PMC_WMASK 8'h1F
// Wake source encodings
`define RWB_WS_NONE 2'h0
`define RWB_WS_RX 2'h1
`define RWB_WS_INT0 2'h2
`define RWB_WS_ANY 2'h3
// Timing in ns and the clock period in ns
`define RWB_CLK_NS 5
`define RWB_PIN_MIN_NS 100
`define RWB_WDT_SEQ_NS 200000
`define RWB_WAKE_EVR_NS 150000
`define RWB_COLD_EVR_NS 300000
`define RWB_PC_START 16'h0000
`endif

/* File: rtl/rwb_pkg.sv */
package rwb_pkg;
	typedef enum logic [2:0] {
		RWB_ST_RESET = 3'b000,
		RWB_ST_EVR = 3'b001,
		RWB_ST_PLL = 3'b010,
		RWB_ST_FLASH = 3'b011,
		RWB_ST_RUN = 3'b100,
		RWB_ST_PDOWN = 3'b101,
		RWB_ST_IDLE = 3'b110
	} rwb_state_t;
	typedef enum logic [1:0] {
		RWB_BOOT_USER = 2'b00,
		RWB_BOOT_LOADER = 2'b01,
		RWB_BOOT_DEBUG = 2'b10,
		RWB_BOOT_JTAG = 2'b11
	} rwb_boot_t;
	typedef struct packed {
		logic osc_running;
		logic pll_locked;
		logic flash_ready;
		logic flash_protected;
	} rwb_clk_status_t;
	typedef struct packed {
		logic pll_attach;
		logic flash_enable;
		logic core_reset_n;
		logic [15:0] pc_start;
	} rwb_seq_out_t;
endpackage

/* File: rtl/rwb_reset_ctrl.sv */
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "rwb_consts.svh"
// Summary of operation
// - Pin release runs the same sequence as a power-on reset.
// - Pin reset ends idle and power-down modes.
// - PLL stays detached until regulator stable; attached only with oscillator running.
// - Once clock stable, Flash banks are made ready to read.
// - Execution starts at address zero after a completed reset.
// - Boot pin and test select decode the boot mode; the port pin is not used.
// - Debug boot is refused while Flash is protected.
// - Watchdog overflow raises NMI first, reset after a time-out.
// - Watchdog reset skips regulator and lock waits, lasting about 200 us.
// - Wake-up reset waits about 150 us for the regulator.
// - Wake source field selects none, serial, interrupt zero, or either.
// - Wake reset select chooses wake with or without reset.
// - Wake flag set by hardware only, cleared by software.
// - Watchdog flag set by hardware only, cleared by software.
// - Register reset value depends on the reset cause.
// - Bit 7 reads zero.
// - Brownout from the core detector when active, or from the power-on detector in power-down, resets the device.
// - Brownout follows the power-on sequence.
// - Boot selection is kept until next power-on, pin or brownout reset.
module rwb_reset_ctrl #(
	parameter int COLD_EVR_CYC = (`RWB_COLD_EVR_NS + `RWB_CLK_NS - 1) / `RWB_CLK_NS,
	parameter int WDT_SEQ_CYC = `RWB_WDT_SEQ_NS / `RWB_CLK_NS,
	parameter int WAKE_EVR_CYC = `RWB_WAKE_EVR_NS / `RWB_CLK_NS,
	parameter int WDT_TIMEOUT_CYC = 64
) (
	// Clock and power-on reset
	input wire logic clk,
	input wire logic resetn,
	// Board pins
	input wire logic pin_reset_n,
	input wire logic boot_config_pin,
	input wire logic test_mode_select,
	input wire logic boot_select_port_pin,
	input wire logic serial_rx,
	input wire logic external_interrupt_zero,
	// Supply, clock and watchdog status
	input wire logic brownout_active,
	input wire logic por_low_pdown,
	input wire logic watchdog_expired,
	input wire logic idle_request,
	input wire rwb_pkg::rwb_clk_status_t clk_status,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Sequencer outputs
	output rwb_pkg::rwb_seq_out_t seq_out,
	output rwb_pkg::rwb_boot_t boot_mode,
	output logic watchdog_nmi,
	output logic in_power_down,
	output logic in_idle
);
	import rwb_pkg::*;

	localparam int PIN_MIN_CYC = (`RWB_PIN_MIN_NS + `RWB_CLK_NS - 1) / `RWB_CLK_NS;
	localparam int PIN_PAST = PIN_MIN_CYC - 1;
	localparam int CW = 24;

	initial begin
		if (COLD_EVR_CYC < 1 || WDT_SEQ_CYC < 1 || WAKE_EVR_CYC < 1 || WDT_TIMEOUT_CYC < 1 ||
			COLD_EVR_CYC >= (1 << CW) || WDT_SEQ_CYC >= (1 << CW) || WAKE_EVR_CYC >= (1 << CW) ||
			WDT_TIMEOUT_CYC > 256)
			$error("rwb_reset_ctrl: timing count out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [1:0] sync_pin;
	logic [1:0] sync_rx;
	logic [1:0] sync_int0;
	logic rx_prev;
	logic int0_prev;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			// Idle high level, so no false pin edge follows reset
			sync_pin <= 2'h3;
			sync_rx <= 2'h3;
			sync_int0 <= 2'h3;
			rx_prev <= 1'b1;
			int0_prev <= 1'b1;
		end else begin
			sync_pin <= {sync_pin[0], pin_reset_n};
			sync_rx <= {sync_rx[0], serial_rx};
			sync_int0 <= {sync_int0[0], external_interrupt_zero};
			rx_prev <= sync_rx[1];
			int0_prev <= sync_int0[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin low-time filter
	logic [7:0] pin_low_cnt;
	logic pin_seen;
	wire pin_low = !sync_pin[1];
	// pin must stay low for the minimum time before it counts
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_low_cnt <= 8'h00;
		end else if (!pin_low) begin
			pin_low_cnt <= 8'h00;
		end else if (pin_low_cnt < 8'(PIN_MIN_CYC)) begin
			pin_low_cnt <= pin_low_cnt + 8'h01;
		end
	end
	wire pin_valid = pin_low && (pin_low_cnt >= 8'(PIN_MIN_CYC - 1));

	////////////////////////////////////////////////////////////////////////
	// Register and state
	rwb_state_t state;
	logic [CW-1:0] cnt;
	logic [7:0] pmc;
	logic [7:0] wdt_cnt;
	logic wdt_pending;
	logic cold_pending;
	logic boot_sampled;

	// Wake source decode
	// Edges are taken from the second synchroniser stage only
	wire rx_fall = rx_prev && !sync_rx[1];
	wire int0_fall = int0_prev && !sync_int0[1];
	wire [1:0] ws = pmc[`RWB_WS_MSB:`RWB_WS_LSB];
	wire wake_evt = (state == RWB_ST_PDOWN) &&
		(((ws == `RWB_WS_RX) && rx_fall) || ((ws == `RWB_WS_INT0) && int0_fall) ||
		((ws == `RWB_WS_ANY) && (rx_fall || int0_fall)));
	wire wake_reset = wake_evt && pmc[`RWB_WAKE_RESET_SELECT_BIT];
	wire wake_plain = wake_evt && !pmc[`RWB_WAKE_RESET_SELECT_BIT];

	// brownout by core detector when active, power-on detector in power-down
	wire brownout = (state == RWB_ST_PDOWN) ? por_low_pdown : brownout_active;
	// pin and brownout start a cold sequence
	wire cold_start = pin_valid || brownout;
	// watchdog reset after the NMI time-out
	wire wdt_fire = wdt_pending && (wdt_cnt == 8'(WDT_TIMEOUT_CYC - 1));

	wire pmc_wr = reg_wr && (reg_addr == `RWB_ADDR_PMC);
	wire [7:0] sw_clear = pmc_wr ? ~reg_wdata : 8'hFF;
	// Writable fields of the power mode register
	wire [7:0] pmc_wval = reg_wdata & `RWB_PMC_WMASK;

	// Watchdog NMI then delay
	// The time-out counter is 8 bits wide, hence the ceiling on its parameter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wdt_pending <= 1'b0;
			wdt_cnt <= 8'h00;
		end else if (cold_start || wdt_fire) begin
			wdt_pending <= 1'b0;
			wdt_cnt <= 8'h00;
		end else if (wdt_pending) begin
			wdt_cnt <= wdt_cnt + 8'h01;
		end else if (watchdog_expired && state == RWB_ST_RUN) begin
			wdt_pending <= 1'b1;
		end
	end
	assign watchdog_nmi = wdt_pending;

	// Sequencer counter load values
	wire [CW-1:0] cold_len = CW'(COLD_EVR_CYC);
	wire [CW-1:0] wake_len = CW'(WAKE_EVR_CYC);
	wire [CW-1:0] wdt_len = CW'(WDT_SEQ_CYC);
	wire cnt_done = (cnt == '0);

	// Reset sequencer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= RWB_ST_RESET;
			cnt <= '0;
			cold_pending <= 1'b1;
		end else if (cold_start) begin
			// pin reset leaves idle and power-down
			state <= RWB_ST_RESET;
			cnt <= cold_len;
			cold_pending <= 1'b1;
		end else if (wdt_fire) begin
			// short watchdog sequence skips regulator and lock waits
			state <= RWB_ST_FLASH;
			cnt <= wdt_len;
			cold_pending <= 1'b0;
		end else if (wake_reset) begin
			// regulator settle time on wake reset
			state <= RWB_ST_EVR;
			cnt <= wake_len;
			cold_pending <= 1'b0;
		end else begin
			unique case (state)
				RWB_ST_RESET: begin
					state <= RWB_ST_EVR;
					cnt <= cold_len;
				end
				RWB_ST_EVR: begin
					if (!cnt_done)
						cnt <= cnt - CW'(1);
					else
						state <= RWB_ST_PLL;
				end
				// attach PLL only with oscillator running, wait for lock
				RWB_ST_PLL: begin
					if (clk_status.osc_running && clk_status.pll_locked)
						state <= RWB_ST_FLASH;
				end
				// Flash made ready once clock is stable
				RWB_ST_FLASH: begin
					if (!cnt_done)
						cnt <= cnt - CW'(1);
					else if (clk_status.flash_ready)
						state <= RWB_ST_RUN;
				end
				RWB_ST_RUN: begin
					if (pmc[`RWB_PD_BIT])
						state <= RWB_ST_PDOWN;
					else if (idle_request)
						state <= RWB_ST_IDLE;
				end
				RWB_ST_PDOWN: begin
					if (wake_plain)
						state <= RWB_ST_RUN;
				end
				RWB_ST_IDLE: begin
					if (!idle_request)
						state <= RWB_ST_RUN;
				end
				default: state <= RWB_ST_RESET;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power mode register
	// reset value follows the reset cause; set wins over clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pmc <= `RWB_PMC_RST_COLD;
		end else if (cold_start) begin
			pmc <= `RWB_PMC_RST_COLD;
		end else if (wdt_fire) begin
			pmc <= `RWB_PMC_RST_WDT;
		end else if (wake_reset) begin
			pmc <= `RWB_PMC_RST_WAKE;
		end else begin
			if (pmc_wr)
				pmc[`RWB_WAKE_RESET_SELECT_BIT:`RWB_WS_LSB] <= pmc_wval[`RWB_WAKE_RESET_SELECT_BIT:`RWB_WS_LSB];
			else if (wake_plain)
				pmc[`RWB_PD_BIT] <= 1'b0;
			pmc[`RWB_WAKE_OCCURRED_FLAG_BIT] <= (pmc[`RWB_WAKE_OCCURRED_FLAG_BIT] & sw_clear[`RWB_WAKE_OCCURRED_FLAG_BIT]) | wake_plain;
			pmc[`RWB_WDT_BIT] <= pmc[`RWB_WDT_BIT] & sw_clear[`RWB_WDT_BIT];
			pmc[`RWB_RSV_BIT] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Boot selection latch
	// decode of boot pins
	wire [1:0] boot_dec = !test_mode_select ?
		(boot_config_pin ? RWB_BOOT_USER : RWB_BOOT_LOADER) :
		(boot_config_pin ? RWB_BOOT_JTAG : RWB_BOOT_DEBUG);
	// debug boot refused while Flash protected
	wire [1:0] boot_ok = (boot_dec == RWB_BOOT_DEBUG && clk_status.flash_protected) ?
		RWB_BOOT_USER : boot_dec;
	wire boot_take = (state == RWB_ST_FLASH) && cnt_done && clk_status.flash_ready &&
		cold_pending && !boot_sampled;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			boot_mode <= RWB_BOOT_USER;
			boot_sampled <= 1'b0;
		end else if (cold_start) begin
			boot_sampled <= 1'b0;
		end else if (boot_take) begin
			boot_mode <= rwb_boot_t'(boot_ok);
			boot_sampled <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				`RWB_ADDR_PMC: next_rdata = {1'b0, pmc[6:0]};
				`RWB_ADDR_STAT: next_rdata = {3'h0, boot_mode, state};
				`RWB_ADDR_CTRL: next_rdata = {4'h0, clk_status};
				default: next_rdata = 8'h00;
			endcase
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= next_rdata;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	logic core_rst_n;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			core_rst_n <= 1'b0;
			in_power_down <= 1'b0;
			in_idle <= 1'b0;
		end else begin
			core_rst_n <= (state == RWB_ST_RUN || state == RWB_ST_IDLE || state == RWB_ST_PDOWN) &&
				!cold_start && !wdt_fire && !wake_reset;
			in_power_down <= (state == RWB_ST_PDOWN);
			in_idle <= (state == RWB_ST_IDLE);
		end
	end
	assign seq_out.pll_attach = (state != RWB_ST_RESET && state != RWB_ST_EVR) && clk_status.osc_running;
	// RUN term bridges the cycle before core_reset_n rises
	assign seq_out.flash_enable = (state == RWB_ST_FLASH && cnt_done) || (state == RWB_ST_RUN) || core_rst_n;
	assign seq_out.core_reset_n = core_rst_n;
	assign seq_out.pc_start = `RWB_PC_START;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_cold;
		cold_start;
	endsequence
	sequence s_wdt_fire;
		wdt_fire && !cold_start;
	endsequence
	sequence s_mode_left;
		!in_idle && !in_power_down;
	endsequence
	pll_detached_a: assert property (@(posedge clk) disable iff (!resetn)
		(state == RWB_ST_EVR) |-> !seq_out.pll_attach) else $error("pll attached early");
	pin_short_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(pin_valid) |-> $past(pin_low, PIN_PAST)) else $error("short pin pulse taken");
	cold_seq_a: assert property (@(posedge clk) disable iff (!resetn)
		s_cold |=> state == RWB_ST_RESET && pmc == `RWB_PMC_RST_COLD) else $error("cold seq wrong");
	wdt_seq_a: assert property (@(posedge clk) disable iff (!resetn)
		s_wdt_fire |=> state == RWB_ST_FLASH && pmc == `RWB_PMC_RST_WDT) else $error("wdt seq wrong");
	wake_seq_a: assert property (@(posedge clk) disable iff (!resetn)
		wake_reset && !cold_start && !wdt_fire |=> state == RWB_ST_EVR && pmc == `RWB_PMC_RST_WAKE)
		else $error("wake seq wrong");
	nmi_first_a: assert property (@(posedge clk) disable iff (!resetn)
		wdt_fire |-> $past(watchdog_nmi)) else $error("reset without nmi");
	debug_lock_a: assert property (@(posedge clk) disable iff (!resetn)
		boot_take && clk_status.flash_protected && !cold_start |=> boot_mode != RWB_BOOT_DEBUG)
		else $error("debug boot while protected");
	reserved_zero_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(reg_rd) |-> !reg_rdata[7]) else $error("reserved bit set");
	boot_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		!$past(boot_take) |-> $stable(boot_mode)) else $error("boot changed");
	wk_sticky_a: assert property (@(posedge clk) disable iff (!resetn)
		pmc[`RWB_WAKE_OCCURRED_FLAG_BIT] && !pmc_wr && !cold_start && !wdt_fire |=> pmc[`RWB_WAKE_OCCURRED_FLAG_BIT])
		else $error("wake flag lost");
	// Mode exits, detector choice, flag set priority and Flash timing
	idle_exit_a: assert property (@(posedge clk) disable iff (!resetn)
		s_cold |-> ##2 s_mode_left)
		else $error("mode kept after pin reset");
	brownout_select_a: assert property (@(posedge clk) disable iff (!resetn)
		(state == RWB_ST_PDOWN) && !por_low_pdown && !pin_valid |=> state != RWB_ST_RESET)
		else $error("core detector used in power-down");
	wake_set_wins_a: assert property (@(posedge clk) disable iff (!resetn)
		wake_plain && !cold_start && !wdt_fire |=> pmc[`RWB_WAKE_OCCURRED_FLAG_BIT])
		else $error("wake flag not set");
	flash_late_a: assert property (@(posedge clk) disable iff (!resetn)
		(state == RWB_ST_PLL) |-> !seq_out.flash_enable)
		else $error("flash enabled before clock stable");
endmodule
